// ==== design/abnc_encoder_counter.sv ====
// abnc_encoder_counter: abn incremental encoder position counter with index handling
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module abnc_encoder_counter #(
	parameter int POS_W = 32
) (
	// clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst_b,
	// encoder inputs
	input  wire logic                        i_enc_a,
	input  wire logic                        i_enc_b,
	input  wire logic                        i_enc_n,
	// register port
	input  wire logic [abnc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [abnc_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [abnc_pkg::DATA_W-1:0] o_rdata,
	// interrupt
	output logic                             o_irq
);

	localparam int FW = abnc_pkg::FRAC_W;

	abnc_pkg::abnc_mode_t             mode_r;
	logic [31:0]                      scale_r;
	logic [POS_W-1:0]                 pos_int_r;
	logic [FW-1:0]                    pos_frac_r;
	logic [POS_W-1:0]                 snap_r;
	logic [abnc_pkg::STAT_W-1:0]      stat_r;
	logic [abnc_pkg::STAT_W-1:0]      mask_r;
	logic [abnc_pkg::STAT_W-1:0]      stat_set;
	logic [2:0]                       clean;
	logic                             a_lvl;
	logic                             b_lvl;
	logic                             n_act;
	logic                             step;
	logic                             up;
	logic                             idx_cond;
	logic                             idx_cond_r;
	logic                             idx_act;
	logic                             wr_mode;
	logic                             wr_pos;
	logic [POS_W-1:0]                 c_int;
	logic [16:0]                      frac_sum;
	logic [16:0]                      frac_dif;
	logic                             carry;
	logic [FW-1:0]                    frac_nxt;
	logic [POS_W-1:0]                 int_nxt;

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	abnc_abn_filter #(
		.N_CH    (3)
	) u_filt (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_raw   ({i_enc_n, i_enc_b, i_enc_a}),
		.o_clean (clean)
	);

	assign a_lvl = clean[0] ^ mode_r.ab_inv;
	assign b_lvl = clean[1] ^ mode_r.ab_inv;
	assign n_act = mode_r.n_act_hi ? clean[2] : ~clean[2];

	abnc_quad_decode u_dec (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_a     (a_lvl),
		.i_b     (b_lvl),
		.o_step  (step),
		.o_up    (up)
	);

	// ----------------------------------------------------------------
	// index qualification
	// ----------------------------------------------------------------
	// event is the start of n active while a and b sit at the chosen levels
	assign idx_cond = n_act && (a_lvl == mode_r.pol_a) && (b_lvl == mode_r.pol_b);
	assign idx_act  = idx_cond && !idx_cond_r && (mode_r.clr_cont || mode_r.clr_once);

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idx_cond_r <= 1'b0;
		end else begin
			idx_cond_r <= idx_cond;
		end
	end

	assign wr_mode = i_wr && (i_addr == abnc_pkg::REG_MODE);
	assign wr_pos  = i_wr && (i_addr == abnc_pkg::REG_POS);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_r <= abnc_pkg::MODE_RST;
		end else if (wr_mode) begin
			mode_r <= i_wdata[abnc_pkg::MODE_W-1:0];
		end else if (idx_act && mode_r.clr_once) begin
			mode_r.clr_once <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scale_r <= abnc_pkg::SCAL_RST;
			mask_r  <= '0;
		end else if (i_wr && (i_addr == abnc_pkg::REG_SCAL)) begin
			scale_r <= i_wdata;
		end else if (i_wr && (i_addr == abnc_pkg::REG_MASK)) begin
			mask_r  <= i_wdata[abnc_pkg::STAT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// scaling arithmetic
	// ----------------------------------------------------------------
	// signed integer part, sign extended to the accumulator width
	assign c_int    = {{(POS_W-abnc_pkg::SCAL_IW){scale_r[31]}}, scale_r[31:16]};
	assign frac_sum = {1'b0, pos_frac_r} + {1'b0, scale_r[15:0]};
	assign frac_dif = {1'b0, pos_frac_r} - {1'b0, scale_r[15:0]};

	always_comb begin
		carry    = 1'b0;
		frac_nxt = '0;
		if (up) begin
			if (mode_r.dec_mode) begin
				carry    = frac_sum >= abnc_pkg::DEC_BASE;
				frac_nxt = carry ? 16'(frac_sum - abnc_pkg::DEC_BASE) : frac_sum[15:0];
			end else begin
				carry    = frac_sum[16];
				frac_nxt = frac_sum[15:0];
			end
			int_nxt = pos_int_r + c_int + POS_W'(carry);
		end else begin
			carry    = frac_dif[16];
			if (mode_r.dec_mode) begin
				frac_nxt = carry ? 16'(frac_dif + abnc_pkg::DEC_BASE) : frac_dif[15:0];
			end else begin
				frac_nxt = frac_dif[15:0];
			end
			int_nxt = pos_int_r - c_int - POS_W'(carry);
		end
	end

	// ----------------------------------------------------------------
	// position accumulator and snapshot
	// ----------------------------------------------------------------
	// software write beats index clear, which beats a count step
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos_int_r  <= '0;
			pos_frac_r <= '0;
		end else if (wr_pos) begin
			pos_int_r  <= i_wdata[POS_W-1:0];
			pos_frac_r <= '0;
		end else if (idx_act && mode_r.clear_on_n) begin
			pos_int_r  <= '0;
			pos_frac_r <= '0;
		end else if (step) begin
			pos_int_r  <= int_nxt;
			pos_frac_r <= frac_nxt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			snap_r <= '0;
		end else if (idx_act) begin
			snap_r <= pos_int_r;
		end
	end

	// ----------------------------------------------------------------
	// event status and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		stat_set                      = '0;
		stat_set[abnc_pkg::STAT_CLR]  = idx_act && mode_r.clear_on_n;
		stat_set[abnc_pkg::STAT_SNAP] = idx_act;
	end

	// a new event in the clearing cycle stays set
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stat_r <= '0;
		end else if (i_wr && (i_addr == abnc_pkg::REG_STAT)) begin
			stat_r <= (stat_r & ~i_wdata[abnc_pkg::STAT_W-1:0]) | stat_set;
		end else begin
			stat_r <= stat_r | stat_set;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_r & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				abnc_pkg::REG_MODE: o_rdata <= 32'(mode_r);
				abnc_pkg::REG_SCAL: o_rdata <= scale_r;
				abnc_pkg::REG_POS:  o_rdata <= 32'(pos_int_r);
				abnc_pkg::REG_SNAP: o_rdata <= 32'(snap_r);
				abnc_pkg::REG_STAT: o_rdata <= 32'(stat_r);
				abnc_pkg::REG_MASK: o_rdata <= 32'(mask_r);
				default:            o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	clear_on_idx_a: assert property (
		idx_act && mode_r.clear_on_n && !wr_pos |=> (pos_int_r == '0) && (pos_frac_r == '0))
		else $error("index did not clear position");

	snap_on_idx_a: assert property (
		idx_act |=> snap_r == $past(pos_int_r))
		else $error("snapshot does not hold position at index");

	once_disarm_a: assert property (
		idx_act && mode_r.clr_once && !wr_mode |=> !mode_r.clr_once)
		else $error("single index flag not cleared");

	cont_keep_a: assert property (
		idx_act && mode_r.clr_cont && !wr_mode |=> mode_r.clr_cont)
		else $error("continuous index flag lost");

	idx_qual_a: assert property (
		(a_lvl != mode_r.pol_a) || (b_lvl != mode_r.pol_b) |=> $stable(snap_r))
		else $error("index accepted at wrong a/b levels");

	idx_unused_a: assert property (
		!mode_r.clr_cont && !mode_r.clr_once |=> $stable(snap_r))
		else $error("index acted while no index flag set");

	bin_add_a: assert property (
		step && !idx_act && !wr_pos && !mode_r.dec_mode && up |=>
			{pos_int_r, pos_frac_r} == $past({pos_int_r, pos_frac_r}) +
				{{(POS_W-abnc_pkg::SCAL_IW){$past(scale_r[31])}}, $past(scale_r)})
		else $error("binary step did not add scale constant");

	bin_sub_a: assert property (
		step && !idx_act && !wr_pos && !mode_r.dec_mode && !up |=>
			{pos_int_r, pos_frac_r} == $past({pos_int_r, pos_frac_r}) -
				{{(POS_W-abnc_pkg::SCAL_IW){$past(scale_r[31])}}, $past(scale_r)})
		else $error("binary step did not subtract scale constant");

	dec_range_a: assert property (
		step && mode_r.dec_mode && !wr_pos && (pos_frac_r < 16'h2710) &&
			(scale_r[15:0] < 16'h2710) |=> pos_frac_r < 16'h2710)
		else $error("decimal fraction left range");

	stat_clr_a: assert property (
		idx_act && mode_r.clear_on_n ##1 !(i_wr && (i_addr == abnc_pkg::REG_STAT)) |->
			stat_r[abnc_pkg::STAT_CLR] [*2])
		else $error("clear event not recorded");

	irq_level_a: assert property (
		o_irq == $past(|(stat_r & mask_r)))
		else $error("interrupt does not follow masked status");

	pos_read_a: assert property (
		$past(i_rd) && ($past(i_addr) == abnc_pkg::REG_POS) |-> o_rdata == 32'($past(pos_int_r)))
		else $error("position read returned wrong value");

	rdata_idle_a: assert property (
		!$past(i_rd) |-> o_rdata == '0)
		else $error("read data not zero outside a read");

endmodule

// ==== design/abnc_pkg.sv ====
// abnc_pkg: shared constants and types of the abn encoder counter
package abnc_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int          ADDR_W   = 8;
	localparam int          DATA_W   = 32;
	localparam logic [7:0]  REG_MODE = 8'h00;
	localparam logic [7:0]  REG_SCAL = 8'h04;
	localparam logic [7:0]  REG_POS  = 8'h08;
	localparam logic [7:0]  REG_SNAP = 8'h0C;
	localparam logic [7:0]  REG_STAT = 8'h10;
	localparam logic [7:0]  REG_MASK = 8'h14;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          MODE_W    = 8;
	localparam logic [7:0]  MODE_RST  = 8'h04;
	localparam logic [31:0] SCAL_RST  = 32'h00010000;
	localparam int          STAT_W    = 2;
	localparam int          STAT_CLR  = 0;
	localparam int          STAT_SNAP = 1;
	localparam int          SCAL_IW   = 16;
	localparam int          FRAC_W    = 16;
	localparam logic [16:0] DEC_BASE  = 17'h02710;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS      = 10;
	localparam int FILT_NS     = 3 * CLK_NS;
	localparam int FILT_CYC    = (FILT_NS + CLK_NS - 1) / CLK_NS;

	// mode register layout, bit 0 is pol_a
	typedef struct packed {
		logic ab_inv;
		logic dec_mode;
		logic clear_on_n;
		logic clr_once;
		logic clr_cont;
		logic n_act_hi;
		logic pol_b;
		logic pol_a;
	} abnc_mode_t;

endpackage

// ==== design/abnc_abn_filter.sv ====
// abnc_abn_filter: spike filter for the a, b and n encoder inputs
`timescale 1ns/1ps
module abnc_abn_filter #(
	parameter int N_CH = 3
) (
	// clock and reset
	input  wire logic            i_mclk,
	input  wire logic            i_rst_b,
	// channels
	input  wire logic [N_CH-1:0] i_raw,
	output logic      [N_CH-1:0] o_clean
);

	// ----------------------------------------------------------------
	// one stability counter per channel
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_ch
			logic [1:0] cnt_r;

			always_ff @(posedge i_mclk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					cnt_r      <= 2'h0;
					o_clean[g] <= 1'b0;
				end else if (i_raw[g] == o_clean[g]) begin
					cnt_r <= 2'h0;
				end else if (cnt_r == 2'(abnc_pkg::FILT_CYC - 1)) begin
					cnt_r      <= 2'h0;
					o_clean[g] <= i_raw[g];
				end else begin
					cnt_r <= cnt_r + 2'h1;
				end
			end

			spike_rej_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
				$changed(o_clean[g]) |-> ($past(i_raw[g], 1) == o_clean[g]) &&
					($past(i_raw[g], 2) == o_clean[g]) && ($past(i_raw[g], 3) == o_clean[g]))
				else $error("filtered input changed after a short pulse");
		end
	endgenerate

endmodule

// ==== design/abnc_quad_decode.sv ====
// abnc_quad_decode: quadrature phase decoder giving a step pulse and direction
`timescale 1ns/1ps
module abnc_quad_decode (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_b,
	// filtered channels
	input  wire logic i_a,
	input  wire logic i_b,
	// count request
	output logic      o_step,
	output logic      o_up
);

	logic a_r;
	logic b_r;

	// ----------------------------------------------------------------
	// edge detection; a change of both channels at once is dropped
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			a_r    <= 1'b0;
			b_r    <= 1'b0;
			o_step <= 1'b0;
			o_up   <= 1'b0;
		end else begin
			a_r    <= i_a;
			b_r    <= i_b;
			o_step <= (i_a ^ a_r) ^ (i_b ^ b_r);
			o_up   <= i_a ^ b_r;
		end
	end

	dir_lead_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(i_a != a_r) && (i_b == b_r) && (i_a != i_b) |=> o_step && o_up)
		else $error("a leading b did not count up");

endmodule

// ==== testbench/abnc_enc_model.sv ====
// abnc_enc_model: behavioural quadrature encoder with index channel
`timescale 1ns/1ps
module abnc_enc_model (
	// clock
	input  wire logic i_mclk,
	// encoder lines
	output logic      o_a,
	output logic      o_b,
	output logic      o_n
);
	int ph = 0;
	initial begin
		o_a = 1'b0;
		o_b = 1'b0;
		o_n = 1'b0;
	end
	// each level set by step and set_n stands 8 clocks, well above the filter length
	task automatic hold();
		repeat (8) @(posedge i_mclk);
	endtask
	// one quadrature edge; a leads b when counting up
	task automatic step(input bit up);
		ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
		@(posedge i_mclk);
		o_a <= (ph == 1 || ph == 2);
		o_b <= (ph >= 2);
		hold();
	endtask
	task automatic set_n(input bit lvl);
		@(posedge i_mclk);
		o_n <= lvl;
		hold();
	endtask
	// two clock spike on a, shorter than the filter
	task automatic spike();
		@(posedge i_mclk);
		o_a <= ~o_a;
		repeat (2) @(posedge i_mclk);
		o_a <= ~o_a;
		hold();
	endtask
endmodule

// ==== testbench/abn_encoder_counter_tb.sv ====
// abn_encoder_counter_tb: self-checking bench of the abn encoder counter
`timescale 1ns/1ps
module abn_encoder_counter_tb;
	logic        i_mclk;
	logic        i_rst_b;
	logic        enc_a;
	logic        enc_b;
	logic        enc_n;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic        o_irq;
	int          bad_count = 0;
	int          total_checks = 0;
	int          e_frac;
	logic [31:0] e_int;
	logic [31:0] scal;
	logic [31:0] rv;
	logic [7:0]  q;
	bit          dec;
	bit          up;
	logic [32:0] tbl [6] = '{33'h000010000, 33'h0FFFF0000, 33'h000008000,
		33'h100191770, 33'h1FFE60FA0, 33'h100000001};

	abnc_encoder_counter DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_enc_a(enc_a), .i_enc_b(enc_b),
		.i_enc_n(enc_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_irq(o_irq));
	abnc_enc_model m (.i_mclk(i_mclk), .o_a(enc_a), .o_b(enc_b), .o_n(enc_n));

	// ----------------------------------------------------------------
	// bus tasks and reference
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		rd(a, rv);
		chk(rv, exp, what);
	endtask
	task automatic setpos(input logic [31:0] p);
		wr(abnc_pkg::REG_POS, p);
		e_int = p;
		e_frac = 0;
	endtask
	// fraction base is 10000 in decimal mode, 2^16 otherwise
	function automatic void ref_step(input bit u);
		int base;
		int f;
		logic [31:0] i;
		base = dec ? 32'h2710 : 32'h10000;
		f = int'(scal[15:0]);
		i = {{16{scal[31]}}, scal[31:16]};
		e_frac = u ? e_frac + f : e_frac - f;
		e_int = u ? e_int + i : e_int - i;
		if (e_frac >= base) begin
			e_frac = e_frac - base;
			e_int = e_int + 32'h1;
		end
		if (e_frac < 0) begin
			e_frac = e_frac + base;
			e_int = e_int - 32'h1;
		end
	endfunction
	// one index pulse; act says whether an action is due
	task automatic idx(input logic [7:0] md, input logic [31:0] p, input bit act, input bit hi);
		logic [31:0] ps;
		rd(abnc_pkg::REG_SNAP, ps);
		setpos(p);
		wr(abnc_pkg::REG_MODE, {24'h0, md});
		m.set_n(hi);
		m.set_n(~hi);
		if (act && md[5])
			e_int = 32'h0;
		rchk(abnc_pkg::REG_POS, e_int, "index position");
		rchk(abnc_pkg::REG_SNAP, act ? p : ps, "snapshot");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		#500000;
		bad_count++;
		stop_test();
	end
	initial begin
		i_rst_b = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		void'($urandom(11));
		repeat (6) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rchk(abnc_pkg::REG_MODE, {24'h0, abnc_pkg::MODE_RST}, "mode reset");
		rchk(abnc_pkg::REG_SCAL, abnc_pkg::SCAL_RST, "scale reset");
		rchk(abnc_pkg::REG_POS, 32'h0, "position reset");
		wr(abnc_pkg::REG_SNAP, 32'h12345678);
		rchk(abnc_pkg::REG_SNAP, 32'h0, "snapshot read only");
		wr(abnc_pkg::REG_MASK, 32'hFFFFFFFF);
		rchk(abnc_pkg::REG_MASK, 32'h3, "mask width");
		rchk(8'h18, 32'h0, "unmapped");
		rchk(abnc_pkg::REG_STAT, 32'h0, "status reset");
		$display("register test done");
		for (int k = 0; k < 14; k++) begin
			{dec, scal} = k < 6 ? tbl[k] : {1'($urandom), 32'($urandom)};
			if (dec)
				scal[15:0] = scal[15:0] % 16'h2710;
			wr(abnc_pkg::REG_SCAL, scal);
			wr(abnc_pkg::REG_MODE, {25'h0, dec, 6'h04});
			setpos(k < 6 ? 32'h7FFFFFFE : 32'($urandom));
			for (int j = 0; j < 8; j++) begin
				up = 1'($urandom);
				m.step(up);
				ref_step(up);
				rchk(abnc_pkg::REG_POS, e_int, "position");
			end
			$display("scale test %0d done", k);
		end
		q = {6'h00, enc_b, enc_a};
		idx(8'h2C | q, 32'h64, 1'b1, 1'b1);
		chk({31'h0, o_irq}, 32'h1, "irq raised");
		rd(abnc_pkg::REG_STAT, rv);
		chk({31'h0, rv[0]}, 32'h1, "clear status");
		wr(abnc_pkg::REG_STAT, 32'h3);
		rchk(abnc_pkg::REG_STAT, 32'h0, "status cleared");
		chk({31'h0, o_irq}, 32'h0, "irq cleared");
		idx(8'h2C | q, 32'h32, 1'b1, 1'b1);
		// continuous mode fires again without rearming
		setpos(32'h3C);
		m.set_n(1'b1);
		m.set_n(1'b0);
		rchk(abnc_pkg::REG_POS, 32'h0, "continuous repeat");
		rchk(abnc_pkg::REG_SNAP, 32'h3C, "continuous snapshot");
		wr(abnc_pkg::REG_STAT, 32'h3);
		wr(abnc_pkg::REG_MASK, 32'h0);
		idx(8'h14 | q, 32'h4D, 1'b1, 1'b1);
		rchk(abnc_pkg::REG_MODE, {24'h0, 8'h04 | q}, "single disarm");
		rchk(abnc_pkg::REG_STAT, 32'h2, "snapshot status");
		chk({31'h0, o_irq}, 32'h0, "irq masked");
		// a second index after the single action is ignored
		setpos(32'h5A);
		m.set_n(1'b1);
		m.set_n(1'b0);
		rchk(abnc_pkg::REG_SNAP, 32'h4D, "single no repeat");
		rchk(abnc_pkg::REG_POS, 32'h5A, "single keeps position");
		idx(8'h04 | q, 32'h21, 1'b0, 1'b1);
		idx(8'h2C | (q ^ 8'h01), 32'h28, 1'b0, 1'b1);
		wr(abnc_pkg::REG_MODE, {24'h0, q});
		m.set_n(1'b1);
		idx(8'h28 | q, 32'h9, 1'b1, 1'b0);
		$display("index test done");
		scal = abnc_pkg::SCAL_RST;
		dec = 1'b0;
		wr(abnc_pkg::REG_SCAL, scal);
		wr(abnc_pkg::REG_MODE, 32'h4);
		setpos(32'h5);
		m.spike();
		rchk(abnc_pkg::REG_POS, 32'h5, "spike ignored");
		m.step(1'b1);
		rchk(abnc_pkg::REG_POS, 32'h6, "step after spike");
		// inverting a and b flips both at once, which must not count
		wr(abnc_pkg::REG_MODE, 32'h84);
		rchk(abnc_pkg::REG_POS, 32'h6, "inversion no step");
		m.step(1'b1);
		rchk(abnc_pkg::REG_POS, 32'h7, "inverted step");
		m.set_n(1'b0);
		q = {6'h00, ~enc_b, ~enc_a};
		idx(8'hAC | q, 32'h11, 1'b1, 1'b1);
		$display("filter test done");
		stop_test();
	end
endmodule
